// [rtl/interval_timer_pkg.sv]
// Constants, field layouts and carrier types for the three-channel interval timer.
package interval_timer_pkg;

  localparam int NUM_COUNTERS = 3;
  localparam real OSC_MHZ = 14.318;
  localparam real COUNT_CLK_MHZ = 1.19;
  localparam int OSC_DIVIDE = $rtoi(OSC_MHZ / COUNT_CLK_MHZ);
  localparam logic [3:0] DIV_LAST = 4'(OSC_DIVIDE - 1);

  localparam logic [1:0] PORT_CONTROL = 2'h3;
  localparam logic [7:0] CONTROL_READ_VALUE = 8'h00;

  localparam int CW_BCD_BIT = 0;
  localparam int CW_MODE_LSB = 1;
  localparam int CW_FUNC_LSB = 4;
  localparam int CW_SEL_LSB = 6;
  localparam int RB_SEL_LSB = 1;
  localparam int RB_STATUS_BIT = 4;
  localparam int RB_COUNT_BIT = 5;

  localparam logic [1:0] FN_LATCH = 2'h0;
  localparam logic [1:0] FN_LOW = 2'h1;
  localparam logic [1:0] FN_HIGH = 2'h2;
  localparam logic [1:0] FN_BOTH = 2'h3;
  localparam logic [1:0] SEL_READBACK = 2'h3;

  localparam logic [2:0] MODE0 = 3'h0;
  localparam logic [2:0] MODE1 = 3'h1;
  localparam logic [2:0] MODE2 = 3'h2;
  localparam logic [2:0] MODE3 = 3'h3;
  localparam logic [2:0] MODE4 = 3'h4;
  localparam logic [2:0] MODE5 = 3'h5;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] data;
  } io_req_t;

  // Status byte order: output level, new count pending, then control bits 5..0.
  typedef struct packed {
    logic [5:0] ctrl;
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] latch;
    logic [7:0] status;
    logic latchVal;
    logic statVal;
    logic wrHi;
    logic rdHi;
    logic newPend;
    logic running;
    logic armed;
    logic outBit;
    logic gatePrev;
  } chan_t;

  localparam chan_t CHAN_RESET = '0;
  localparam logic [7:0] RD_RESET = 8'h00;

endpackage

// [rtl/three_channel_interval_timer.sv]
// Three independent down-counters with control, latch, read-back and status ports.
// Summary of operation
// - Control word picks mode; counts accepted anytime.
// - Modes 0,1,4,5 wrap to FFFF or 9999.
// - Gate low holds count except mode 1.
// - Mode 0: out low on load, high sticky.
// - Modes 0,4: new count loads next tick.
// - Mode 1: gate rise reloads and starts.
// - Mode 1: out low on trigger, high at zero.
// - Mode 1: new count waits for gate rise.
// - Modes 2,3 auto reload; gate rise reloads.
// - Mode 2: one-tick low pulse at one.
// - Modes 2,3,5: new count at one (mode 5: zero) or rise.
// - Mode 3: high first half, low second.
// - Mode 3: gate low forces out high.
// - Modes 4,5: one-tick low strobe at zero.
// - Latch command freezes a readable snapshot.
// - Read-back bit5 clear latches every selected counter.
// - Read-back bit4 clear returns status next read.
// - Status: control bits, pending flag, output.
// - Control word field layout and functions.
// - Counters tick at oscillator divided by twelve.
// - Gates 0,1 high; gate 2 from pin.
module three_channel_interval_timer (
  input logic ref_clk,
  input logic rst_b,
  input logic clkEn,
  input interval_timer_pkg::io_req_t ioReq,
  output logic [7:0] ioRdData,
  input logic refOscIn,
  input logic counter2_gate_input,
  output logic [interval_timer_pkg::NUM_COUNTERS-1:0] counterOut
);
  import interval_timer_pkg::*;

  chan_t chanState_reg [NUM_COUNTERS];
  chan_t chanState_next [NUM_COUNTERS];
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic [2:0] oscSync_reg;
  logic [1:0] gateSync_reg;
  logic [3:0] div_reg;
  logic [3:0] div_next;

  function automatic logic [2:0] effMode(input logic [2:0] m);
    return (m[1]) ? {1'b0, m[1:0]} : m;
  endfunction

  // BCD borrow ripples nibble by nibble, so zero wraps to 9999.
  function automatic logic [15:0] decCount(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd)
    begin
      r = v - 16'h0001;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (borrow)
        begin
          if (r[k*4 +: 4] == 4'h0)
          begin
            r[k*4 +: 4] = 4'h9;
          end
          else
          begin
            r[k*4 +: 4] = r[k*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // The edge detector reads only the last two stages, so the first may settle safely.
  wire oscRise = oscSync_reg[1] & ~oscSync_reg[2];
  wire tick = oscRise & (div_reg == DIV_LAST);
  wire gate2Sync = gateSync_reg[1];
  wire counter0_gate_input = 1'b1;
  wire counter1_gate_input = 1'b1;
  wire [2:0] gateVec = {gate2Sync, counter1_gate_input, counter0_gate_input};
  wire ctrlWr = ioReq.wr & (ioReq.addr == PORT_CONTROL);
  wire rbWr = ctrlWr & (ioReq.data[CW_SEL_LSB +: 2] == SEL_READBACK);
  wire cwWr = ctrlWr & ~rbWr;
  wire [1:0] cwFunc = ioReq.data[CW_FUNC_LSB +: 2];

  assign div_next = !oscRise ? div_reg : (tick ? 4'h0 : div_reg + 4'h1);
  assign counterOut = {chanState_reg[2].outBit, chanState_reg[1].outBit,
    chanState_reg[0].outBit};
  assign ioRdData = rdData_reg;

  always_comb
  begin
    chan_t c;
    logic [2:0] mode;
    logic [15:0] view;
    logic gate;
    logic rise;
    logic done;
    logic loadNow;
    c = CHAN_RESET;
    mode = MODE0;
    view = 16'h0000;
    gate = 1'b0;
    rise = 1'b0;
    done = 1'b0;
    loadNow = 1'b0;
    rdData_next = CONTROL_READ_VALUE;
    for (int i = 0; i < NUM_COUNTERS; i++)
    begin
      c = chanState_reg[i];
      gate = gateVec[i];
      if (cwWr && ioReq.data[CW_SEL_LSB +: 2] == 2'(i))
      begin
        if (cwFunc == FN_LATCH)
        begin
          if (!c.latchVal)
          begin
            c.latch = c.count;
            c.latchVal = 1'b1;
          end
        end
        else
        begin
          c.ctrl = ioReq.data[5:0];
          c.wrHi = 1'b0;
          c.rdHi = 1'b0;
          c.latchVal = 1'b0;
          c.running = 1'b0;
          c.outBit = (effMode(ioReq.data[CW_MODE_LSB +: 3]) != MODE0);
        end
      end
      if (rbWr && ioReq.data[RB_SEL_LSB + i])
      begin
        if (!ioReq.data[RB_COUNT_BIT] && !c.latchVal)
        begin
          c.latch = c.count;
          c.latchVal = 1'b1;
        end
        if (!ioReq.data[RB_STATUS_BIT] && !c.statVal)
        begin
          c.status = {c.outBit, c.newPend, c.ctrl};
          c.statVal = 1'b1;
        end
      end
      mode = effMode(c.ctrl[CW_MODE_LSB +: 3]);
      done = 1'b0;
      if (ioReq.wr && ioReq.addr == 2'(i))
      begin
        case (c.ctrl[CW_FUNC_LSB +: 2])
          FN_LOW:
          begin
            c.reload = {8'h00, ioReq.data};
            done = 1'b1;
          end
          FN_HIGH:
          begin
            c.reload = {ioReq.data, 8'h00};
            done = 1'b1;
          end
          FN_BOTH:
          begin
            if (!c.wrHi)
            begin
              c.reload[7:0] = ioReq.data;
            end
            else
            begin
              c.reload[15:8] = ioReq.data;
              done = 1'b1;
            end
            c.wrHi = ~c.wrHi;
          end
          default: done = 1'b0;
        endcase
        if (done)
        begin
          c.newPend = 1'b1;
          if (mode == MODE0)
          begin
            c.outBit = 1'b0;
          end
        end
      end
      if (ioReq.rd && ioReq.addr == 2'(i))
      begin
        view = c.latchVal ? c.latch : c.count;
        if (c.statVal)
        begin
          rdData_next = c.status;
          c.statVal = 1'b0;
        end
        else if (c.ctrl[CW_FUNC_LSB +: 2] == FN_HIGH)
        begin
          rdData_next = view[15:8];
          c.latchVal = 1'b0;
        end
        else if (c.ctrl[CW_FUNC_LSB +: 2] == FN_BOTH && c.rdHi)
        begin
          rdData_next = view[15:8];
          c.latchVal = 1'b0;
          c.rdHi = 1'b0;
        end
        else
        begin
          rdData_next = view[7:0];
          c.rdHi = (c.ctrl[CW_FUNC_LSB +: 2] == FN_BOTH);
          c.latchVal = c.latchVal & c.rdHi;
        end
      end
      if (tick)
      begin
        rise = gate & ~c.gatePrev;
        c.gatePrev = gate;
        if (mode == MODE1)
        begin
          loadNow = rise;
        end
        else if (mode == MODE0 || mode == MODE4)
        begin
          loadNow = c.newPend;
        end
        else
        begin
          loadNow = (c.newPend && !c.running) || rise;
        end
        if (loadNow)
        begin
          c.count = c.reload;
          c.newPend = 1'b0;
          c.running = 1'b1;
          c.armed = 1'b1;
          c.outBit = !(mode == MODE0 || mode == MODE1);
        end
        else if (c.running && (gate || mode == MODE1))
        begin
          if (((mode == MODE2 || mode == MODE3) && c.count == 16'h0001)
            || (mode == MODE5 && c.newPend && c.count == 16'h0000))
          begin
            c.count = c.reload;
            c.newPend = 1'b0;
            c.armed = 1'b1;
          end
          else
          begin
            c.count = decCount(c.count, c.ctrl[CW_BCD_BIT]);
          end
          case (mode)
            MODE0, MODE1: c.outBit = c.outBit | (c.count == 16'h0000);
            MODE2: c.outBit = (c.count != 16'h0001);
            MODE3: c.outBit = (c.count > {1'b0, c.reload[15:1]});
            default:
            begin
              c.outBit = !(c.armed && c.count == 16'h0000);
              c.armed = c.armed & (c.count != 16'h0000);
            end
          endcase
        end
      end
      if (mode == MODE3 && !gate)
      begin
        c.outBit = 1'b1;
      end
      chanState_next[i] = c;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      chanState_reg <= '{default: CHAN_RESET};
      rdData_reg <= RD_RESET;
      oscSync_reg <= 3'h0;
      gateSync_reg <= 2'h0;
      div_reg <= 4'h0;
    end
    else if (clkEn)
    begin
      chanState_reg <= chanState_next;
      oscSync_reg <= {oscSync_reg[1:0], refOscIn};
      gateSync_reg <= {gateSync_reg[0], counter2_gate_input};
      div_reg <= div_next;
      if (ioReq.rd)
      begin
        rdData_reg <= rdData_next;
      end
    end
  end

  // Checks other than a_tick_spacing watch counter 2, the only channel whose gate can be driven from outside.
  wire [2:0] modeC2 = effMode(chanState_reg[2].ctrl[CW_MODE_LSB +: 3]);
  wire idleC2 = clkEn & ~ioReq.wr & ~ioReq.rd;
  wire steadyGate = gate2Sync & chanState_reg[2].gatePrev;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_wrap_binary: assert property (idleC2 && tick && steadyGate && modeC2 == MODE0
    && chanState_reg[2].running && !chanState_reg[2].newPend
    && !chanState_reg[2].ctrl[0] && chanState_reg[2].count == 16'h0000
    |=> chanState_reg[2].count == 16'hFFFF) else $error("Binary count did not wrap.");
  a_gate_hold: assert property (idleC2 && !gate2Sync && !chanState_reg[2].gatePrev
    && modeC2 != MODE1 && !chanState_reg[2].newPend
    |=> $stable(chanState_reg[2].count)) else $error("Count moved with gate low.");
  a_mode0_sticky: assert property (idleC2 && modeC2 == MODE0 && counterOut[2]
    |=> counterOut[2]) else $error("Mode 0 output fell without a write.");
  a_mode1_trigger: assert property (clkEn && tick && modeC2 == MODE1 && gate2Sync
    && !chanState_reg[2].gatePrev && !ioReq.wr
    |=> !counterOut[2] && chanState_reg[2].running) else $error("Trigger missed.");
  a_mode2_pulse: assert property (idleC2 && tick && steadyGate && modeC2 == MODE2
    && chanState_reg[2].running && chanState_reg[2].count == 16'h0002
    |=> !counterOut[2] ##1 (!tick) [*1]) else $error("Mode 2 pulse missing.");
  a_mode3_gate: assert property (clkEn && modeC2 == MODE3 && !gate2Sync
    && !ioReq.wr |=> counterOut[2]) else $error("Mode 3 output not forced high.");
  a_latch_freeze: assert property (clkEn && chanState_reg[2].latchVal && !ioReq.rd
    && !ioReq.wr |=> $stable(chanState_reg[2].latch) && chanState_reg[2].latchVal)
    else $error("Latched count changed.");
  a_status_read: assert property (clkEn && ioReq.rd && ioReq.addr == 2'h2
    && chanState_reg[2].statVal |=> ioRdData == $past(chanState_reg[2].status)
    && !chanState_reg[2].statVal) else $error("Status byte not returned.");
  a_tick_spacing: assert property (tick |=> !tick [*8])
    else $error("Counter ticks too close.");

  c_mode2_run: cover property (modeC2 == MODE2 && tick && !counterOut[2]);
  c_readback: cover property (rbWr ##[1:20] chanState_reg[2].statVal && ioReq.rd);
  c_mode1_retrig: cover property (modeC2 == MODE1 && tick && gate2Sync
    && !chanState_reg[2].gatePrev && chanState_reg[2].running);

endmodule // three_channel_interval_timer

// [sim/host_io_model.sv]
// Host processor model that issues byte-wide port reads and writes.
module host_io_model (
  input logic ref_clk,
  output interval_timer_pkg::io_req_t ioReq,
  input logic [7:0] ioRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  import interval_timer_pkg::*;

  initial ioReq = '0;

  // The data lines show the inverse once released, so stale bytes are never mistaken for fresh.
  task automatic put(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 ioReq = {1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    #1 ioReq = {1'b0, 1'b0, a, ~d};
  endtask

  task automatic get(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 ioReq = {1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    #1 ioReq = {1'b0, 1'b0, a, 8'hFF};
    d = ioRdData;
  endtask
endmodule // host_io_model

// [sim/tb_top.sv]
// Self-checking bench for the three-channel interval timer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import interval_timer_pkg::*;
  logic ref_clk, rst_b, clkEn, refOscIn, counter2_gate_input;
  io_req_t ioReq;
  logic [7:0] ioRdData, rd;
  logic [2:0] counterOut;
  int expQ[$];
  int n_mismatch, compares, seed, nRand, nTick;

  three_channel_interval_timer u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn),
    .ioReq(ioReq), .ioRdData(ioRdData), .refOscIn(refOscIn),
    .counter2_gate_input(counter2_gate_input), .counterOut(counterOut));
  host_io_model u_host (.ref_clk(ref_clk), .ioReq(ioReq), .ioRdData(ioRdData));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int dn(int c, int n, bit bcd);
    repeat (n) c = bcd ? (c == 0 ? 9999 : c - 1) : (c + 65535) % 65536;
    return c;
  endfunction

  function automatic logic [15:0] h(int d, bit bcd);
    return bcd ? 16'((d / 1000) * 4096 + (d / 100 % 10) * 256 + (d / 10 % 10) * 16 + d % 10)
               : 16'(d);
  endfunction

  // The oscillator only runs inside this task, so every count is frozen while the host talks.
  task automatic tick(int n);
    repeat (12 * n)
    begin
      repeat (4) @(posedge ref_clk);
      #1 refOscIn = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 refOscIn = 1'b0;
    end
    nTick += n;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic prog(logic [7:0] cw, logic [15:0] c);
    u_host.put(PORT_CONTROL, cw);
    u_host.put(cw[7:6], c[7:0]);
    u_host.put(cw[7:6], c[15:8]);
  endtask

  task automatic rdcnt(logic [1:0] ch, logic [15:0] exp);
    expQ.push_back(int'(exp[7:0]));
    expQ.push_back(int'(exp[15:8]));
    repeat (2)
    begin
      u_host.get(ch, rd);
      check(16'(rd), 16'(expQ.pop_front()));
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    seed = 59158;
    clkEn = 1'b1;
    rst_b = 1'b0;
    refOscIn = 1'b0;
    counter2_gate_input = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    prog(8'h30, 16'h0005);
    u_host.put(PORT_CONTROL, 8'hEA);
    u_host.get(2'h0, rd);
    check(16'(rd), 16'h0070);
    u_host.get(2'h2, rd);
    check(16'(rd), 16'h0000);
    tick(5);
    check(16'(counterOut[0]), 16'h0000);
    tick(1);
    check(16'(counterOut[0]), 16'h0001);
    tick(2);
    u_host.put(PORT_CONTROL, 8'h00);
    tick(1);
    rdcnt(2'h0, h(dn(5, 7, 0), 0));
    prog(8'h71, 16'h0001);
    prog(8'hB0, 16'h0001);
    tick(3);
    u_host.put(PORT_CONTROL, 8'hDC);
    rdcnt(2'h1, h(dn(1, 2, 1), 1));
    rdcnt(2'h2, h(dn(1, 2, 0), 0));
    prog(8'hB4, 16'h0003);
    tick(2);
    check(16'(counterOut[2]), 16'h0001);
    tick(1);
    check(16'(counterOut[2]), 16'h0000);
    tick(1);
    check(16'(counterOut[2]), 16'h0001);
    u_host.put(2'h2, 8'h04);
    u_host.put(2'h2, 8'h00);
    tick(3);
    u_host.put(PORT_CONTROL, 8'hDA);
    rdcnt(2'h0, h(dn(5, nTick - 1, 0), 0));
    rdcnt(2'h2, 16'h0004);
    prog(8'hB6, 16'h0006);
    tick(3);
    check(16'(counterOut[2]), 16'h0001);
    tick(1);
    check(16'(counterOut[2]), 16'h0000);
    counter2_gate_input = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 check(16'(counterOut[2]), 16'h0001);
    tick(2);
    u_host.put(PORT_CONTROL, 8'h80);
    rdcnt(2'h2, 16'h0003);
    prog(8'hB2, 16'h0002);
    tick(1);
    counter2_gate_input = 1'b1;
    tick(1);
    check(16'(counterOut[2]), 16'h0000);
    u_host.put(2'h2, 8'h07);
    u_host.put(2'h2, 8'h00);
    tick(2);
    check(16'(counterOut[2]), 16'h0001);
    u_host.put(PORT_CONTROL, 8'h80);
    rdcnt(2'h2, 16'h0000);
    counter2_gate_input = 1'b0;
    tick(1);
    counter2_gate_input = 1'b1;
    tick(1);
    u_host.put(PORT_CONTROL, 8'h80);
    rdcnt(2'h2, 16'h0007);
    prog(8'hBA, 16'h0002);
    tick(3);
    check(16'(counterOut[2]), 16'h0000);
    tick(1);
    check(16'(counterOut[2]), 16'h0001);
    counter2_gate_input = 1'b0;
    tick(1);
    counter2_gate_input = 1'b1;
    tick(3);
    check(16'(counterOut[2]), 16'h0000);
    nRand = 2 + ($unsigned($random(seed)) % 4);
    prog(8'h38, 16'(nRand));
    tick(nRand);
    check(16'(counterOut[0]), 16'h0001);
    tick(1);
    check(16'(counterOut[0]), 16'h0000);
    tick(1);
    check(16'(counterOut[0]), 16'h0001);
    clkEn = 1'b0;
    tick(2);
    clkEn = 1'b1;
    u_host.put(PORT_CONTROL, 8'h00);
    rdcnt(2'h0, 16'hFFFF);
    u_host.get(PORT_CONTROL, rd);
    check(16'(rd), 16'h0000);
    finish_test();
  end
endmodule // tb_top
